// file: design/sil_pkg.sv
// Shared constants and types for the serial input select, signal-loss and lock block
package sil_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int LOS_WINDOW_NS   = 5000;
	localparam int LOS_WINDOW_CYC  = (LOS_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOS_MIN_RUN_NS  = 16;
	localparam int LOS_MIN_RUN_CYC = (LOS_MIN_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pin synchroniser width and bit positions
	localparam int SYNC_W     = 14;
	localparam int PIN_EQ0    = 0;
	localparam int PIN_SEL0   = 4;
	localparam int PIN_HIF    = 6;
	localparam int PIN_VID0   = 7;
	localparam int PIN_FREQ   = 11;
	localparam int PIN_PHASE  = 12;
	localparam int PIN_HARM   = 13;

	// Host register addresses
	localparam logic [7:0] ADDR_LOSS_CTL = 8'h02;
	localparam logic [7:0] ADDR_RCK_CTL  = 8'h03;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;

	// Host frame layout
	localparam logic [5:0] SPI_CMD_LAST  = 6'h0f;
	localparam logic [5:0] SPI_DATA_LAST = 6'h1f;
	localparam logic [5:0] SPI_DONE      = 6'h20;
	localparam int         SPI_RD_BIT    = 15;

	// Trace equalizer settings
	localparam logic [1:0] EQ_LOW  = 2'h0;
	localparam logic [1:0] EQ_MED  = 2'h1;
	localparam logic [1:0] EQ_HIGH = 2'h2;

	// Reclock rates
	localparam logic [1:0] RATE_270M  = 2'h1;
	localparam logic [1:0] RATE_1485M = 2'h2;
	localparam logic [1:0] RATE_2970M = 2'h3;

	typedef struct packed {
		logic [10:0] rsvd;
		logic        automute;
		logic        method;
		logic        sdo_tristate;
		logic [1:0]  threshold;
	} sil_loss_ctl_t;

	typedef struct packed {
		logic [11:0] rsvd;
		logic [1:0]  rate;
		logic [1:0]  eq_gain;
	} sil_rck_ctl_t;

	localparam sil_loss_ctl_t LOSS_CTL_RST = '{rsvd: 11'h000, automute: 1'b1, method: 1'b1,
		sdo_tristate: 1'b0, threshold: 2'h0};
	// Medium gain suits roughly ten inches of stripline
	localparam sil_rck_ctl_t RCK_CTL_RST = '{rsvd: 12'h000, rate: RATE_2970M, eq_gain: EQ_MED};

endpackage : sil_pkg

// file: design/sil_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module sil_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk) begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// Stage one feeds only stage two; filtering starts at stage two
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_out <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					pin_out[i] <= s3_r[i];
				end
			end
		end
	end

endmodule : sil_sync

// file: design/sil_front.sv
// Input select, trace equalizer control, signal-loss detection, mute and lock status
`timescale 1ns/1ns
module sil_front (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       host_port_select_n,
	input  wire logic       host_din_eq_enable_0,
	input  wire logic       host_dout_eq_enable_1_i,
	output logic            host_dout_eq_enable_1_o,
	output logic            host_dout_eq_enable_1_oe,
	input  wire logic       host_clock_eq_enable_2,
	input  wire logic       host_select_eq_enable_3,
	input  wire logic [1:0] input_select,
	input  wire logic [3:0] serial_video_input,
	input  wire logic       pll_freq_ok,
	input  wire logic       pll_phase_ok,
	input  wire logic       pll_harmonic,
	output logic [3:0]      input_power_en,
	output logic [7:0]      trace_eq_setting,
	output logic            serial_data_out,
	output logic            data_mute,
	output logic            signal_loss_flag,
	output logic            locked,
	output logic            ref_clock_track,
	output logic [1:0]      reclock_rate
);

	logic [sil_pkg::SYNC_W-1:0] pin_s;
	logic                       spi_mode;
	logic [3:0]                 eq_pin;
	logic [1:0]                 sel;
	logic [3:0]                 vid_s;
	logic                       sck_prev_r;
	logic [5:0]                 bit_cnt_r;
	logic [15:0]                shift_r;
	logic [15:0]                cmd_r;
	logic [15:0]                tx_r;
	sil_pkg::sil_loss_ctl_t     loss_ctl_r;
	sil_pkg::sil_rck_ctl_t      rck_ctl_r;
	logic                       sck_rise;
	logic                       sck_fall;
	logic [1:0]                 sel_prev_r;
	logic                       sel_chg;
	logic                       vid_prev_r;
	logic                       vid_cur;
	logic                       vid_edge;
	logic [9:0]                 win_cnt_r;
	logic [3:0]                 run_cnt_r;
	logic [3:0]                 edge_cnt_r;
	logic                       edge_ok;
	logic [3:0]                 edge_thr;
	logic [9:0]                 quiet_cnt_r;

	function automatic logic [3:0] thr_edges(input logic [1:0] code);
		logic [3:0] n;
		n = 4'h4 - {2'h0, code};
		return n;
	endfunction : thr_edges

	function automatic logic [15:0] rd_word(
		input logic [7:0]             a,
		input sil_pkg::sil_loss_ctl_t lc,
		input sil_pkg::sil_rck_ctl_t  rc,
		input logic [3:0]             st
	);
		logic [15:0] d;
		d = 16'h0000;
		if (a == sil_pkg::ADDR_LOSS_CTL) begin
			d = lc;
		end else if (a == sil_pkg::ADDR_RCK_CTL) begin
			d = rc;
		end else if (a == sil_pkg::ADDR_STATUS) begin
			d = {12'h000, st};
		end
		return d;
	endfunction : rd_word

	sil_sync #(
		.W(sil_pkg::SYNC_W)
	) u_sync (
		.clk    (clk),
		.sys_rst(sys_rst),
		.pin_in ({pll_harmonic, pll_phase_ok, pll_freq_ok, serial_video_input, host_port_select_n,
			input_select, host_select_eq_enable_3, host_clock_eq_enable_2, host_dout_eq_enable_1_i,
			host_din_eq_enable_0}),
		.pin_out(pin_s)
	);

	assign spi_mode = ~pin_s[sil_pkg::PIN_HIF];
	assign eq_pin   = pin_s[sil_pkg::PIN_EQ0 +: 4];
	assign sel      = pin_s[sil_pkg::PIN_SEL0 +: 2];
	assign vid_s    = pin_s[sil_pkg::PIN_VID0 +: 4];

	// Host port: chip select active low, data sampled on clock rise, shifted out on fall
	assign sck_rise = spi_mode & ~pin_s[3] & pin_s[2] & ~sck_prev_r;
	assign sck_fall = spi_mode & ~pin_s[3] & ~pin_s[2] & sck_prev_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_prev_r <= 1'b0;
		end else begin
			sck_prev_r <= pin_s[2];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !spi_mode || pin_s[3]) begin
			bit_cnt_r <= 6'h00;
			shift_r   <= 16'h0000;
		end else if (sck_rise && bit_cnt_r != sil_pkg::SPI_DONE) begin
			bit_cnt_r <= bit_cnt_r + 6'h01;
			shift_r   <= {shift_r[14:0], pin_s[0]};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_r <= 16'h0000;
		end else if (sck_rise && bit_cnt_r == sil_pkg::SPI_CMD_LAST) begin
			cmd_r <= {shift_r[14:0], pin_s[0]};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_r <= 16'h0000;
		end else if (sck_rise && bit_cnt_r == sil_pkg::SPI_CMD_LAST) begin
			tx_r <= rd_word(shift_r[6:0] == 7'h00 ? {shift_r[6:0], pin_s[0]} : {shift_r[6:0], pin_s[0]},
				loss_ctl_r, rck_ctl_r, {sel, signal_loss_flag, locked});
		end else if (sck_fall && bit_cnt_r > sil_pkg::SPI_CMD_LAST) begin
			tx_r <= {tx_r[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_dout_eq_enable_1_o <= 1'b0;
		end else if (sck_fall && bit_cnt_r > sil_pkg::SPI_CMD_LAST) begin
			host_dout_eq_enable_1_o <= tx_r[15];
		end
	end

	// Pin is an input in legacy mode; optional release while deselected in host mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_dout_eq_enable_1_oe <= 1'b0;
		end else begin
			host_dout_eq_enable_1_oe <= spi_mode & (~loss_ctl_r.sdo_tristate | ~pin_s[3]);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !spi_mode) begin
			loss_ctl_r <= sil_pkg::LOSS_CTL_RST;
		end else if (sck_rise && bit_cnt_r == sil_pkg::SPI_DATA_LAST && !cmd_r[sil_pkg::SPI_RD_BIT]
				&& cmd_r[7:0] == sil_pkg::ADDR_LOSS_CTL) begin
			loss_ctl_r <= {11'h000, shift_r[3:0], pin_s[0]};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !spi_mode) begin
			rck_ctl_r <= sil_pkg::RCK_CTL_RST;
		end else if (sck_rise && bit_cnt_r == sil_pkg::SPI_DATA_LAST && !cmd_r[sil_pkg::SPI_RD_BIT]
				&& cmd_r[7:0] == sil_pkg::ADDR_RCK_CTL) begin
			rck_ctl_r.eq_gain <= (shift_r[0] & pin_s[0]) ? sil_pkg::EQ_HIGH : {shift_r[0], pin_s[0]};
			rck_ctl_r.rate    <= (shift_r[2:1] == 2'h0) ? rck_ctl_r.rate : shift_r[2:1];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			input_power_en <= 4'h0;
		end else begin
			input_power_en <= 4'h1 << sel;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trace_eq_setting <= 8'h00;
		end else begin
			for (int n = 0; n < 4; n++) begin
				if (sel != n[1:0]) begin
					trace_eq_setting[2*n +: 2] <= sil_pkg::EQ_LOW;
				end else if (spi_mode) begin
					trace_eq_setting[2*n +: 2] <= rck_ctl_r.eq_gain;
				end else if (eq_pin[n]) begin
					trace_eq_setting[2*n +: 2] <= sil_pkg::EQ_MED;
				end else begin
					trace_eq_setting[2*n +: 2] <= sil_pkg::EQ_LOW;
				end
			end
		end
	end

	assign vid_cur  = vid_s[sel];
	assign sel_chg  = sel != sel_prev_r;
	assign vid_edge = (vid_cur ^ vid_prev_r) & ~sel_chg;
	assign edge_ok  = vid_edge & (~loss_ctl_r.method || run_cnt_r >= 4'(sil_pkg::LOS_MIN_RUN_CYC));
	assign edge_thr = thr_edges(loss_ctl_r.threshold);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel_prev_r <= 2'h0;
			vid_prev_r <= 1'b0;
		end else begin
			sel_prev_r <= sel;
			vid_prev_r <= vid_cur;
		end
	end

	// Short pulses after a long idle are typical of crosstalk, so run length gates them
	always_ff @(posedge clk) begin
		if (sys_rst || vid_edge || sel_chg) begin
			run_cnt_r <= 4'h0;
		end else if (run_cnt_r != 4'hf) begin
			run_cnt_r <= run_cnt_r + 4'h1;
		end
	end

	// quiet time since the last edge
	// A window may end just after the input went idle; this keeps loss from being flagged before 5 us of quiet
	always_ff @(posedge clk) begin
		if (sys_rst || vid_edge || sel_chg) begin
			quiet_cnt_r <= 10'h000;
		end else if (quiet_cnt_r != 10'h3ff) begin
			quiet_cnt_r <= quiet_cnt_r + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || sel_chg || win_cnt_r == 10'(sil_pkg::LOS_WINDOW_CYC - 1)) begin
			win_cnt_r <= 10'h000;
		end else begin
			win_cnt_r <= win_cnt_r + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || sel_chg || win_cnt_r == 10'(sil_pkg::LOS_WINDOW_CYC - 1)) begin
			edge_cnt_r <= 4'h0;
		end else if (edge_ok && edge_cnt_r != 4'hf) begin
			edge_cnt_r <= edge_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			signal_loss_flag <= 1'b1;
		end else if (edge_ok && edge_cnt_r + 4'h1 >= edge_thr) begin
			signal_loss_flag <= 1'b0;
		// window end check, only after a full window of quiet
		end else if (!sel_chg && !vid_edge && win_cnt_r == 10'(sil_pkg::LOS_WINDOW_CYC - 1)
				&& edge_cnt_r < edge_thr && quiet_cnt_r >= 10'(sil_pkg::LOS_WINDOW_CYC - 1)) begin
			signal_loss_flag <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_mute       <= 1'b1;
			serial_data_out <= 1'b1;
		end else begin
			data_mute       <= signal_loss_flag & loss_ctl_r.automute;
			serial_data_out <= (signal_loss_flag & loss_ctl_r.automute) | vid_cur;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			locked <= 1'b0;
		end else begin
			locked <= pin_s[sil_pkg::PIN_FREQ] & pin_s[sil_pkg::PIN_PHASE] & ~pin_s[sil_pkg::PIN_HARM]
				& ~signal_loss_flag;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ref_clock_track <= 1'b1;
		end else begin
			ref_clock_track <= signal_loss_flag;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reclock_rate <= sil_pkg::RATE_2970M;
		end else begin
			reclock_rate <= rck_ctl_r.rate;
		end
	end

endmodule : sil_front

// file: tb/sil_front_asserts.sv
// Port-level checker for the input select, signal-loss and lock block
`timescale 1ns/1ns
module sil_front_asserts (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       host_port_select_n,
	input wire logic       host_dout_eq_enable_1_oe,
	input wire logic [1:0] input_select,
	input wire logic [3:0] serial_video_input,
	input wire logic [3:0] input_power_en,
	input wire logic [7:0] trace_eq_setting,
	input wire logic       serial_data_out,
	input wire logic       data_mute,
	input wire logic       signal_loss_flag,
	input wire logic       locked,
	input wire logic       ref_clock_track
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic [9:0] quiet_r;
	logic       last_r;
	logic [1:0] sel_r;
	logic [7:0] eq_mask;

	// Quiet time is counted on the raw pin, so it leads the synced view by a few clocks
	always_ff @(posedge clk) begin
		if (sys_rst || serial_video_input[input_select] != last_r || input_select != sel_r)
			quiet_r <= 10'h000;
		else if (quiet_r != 10'h3ff)
			quiet_r <= quiet_r + 10'h001;
		last_r <= serial_video_input[input_select];
		sel_r  <= input_select;
	end

	assign eq_mask = {{2{input_power_en[3]}}, {2{input_power_en[2]}}, {2{input_power_en[1]}}, {2{input_power_en[0]}}};

	a_power_follows_select: assert property ($stable(input_select) [*8] |->
		input_power_en == (4'h1 << input_select))
		else $error("power enable does not match select");
	a_eq_selected_only: assert property ((trace_eq_setting & ~eq_mask) == 8'h00)
		else $error("equalizer active on unselected input");
	a_mute_needs_loss: assert property (data_mute |-> $past(signal_loss_flag))
		else $error("mute without loss");
	a_mute_forces_high: assert property (data_mute |-> serial_data_out)
		else $error("muted output not high");
	a_lock_needs_valid: assert property (locked |-> !$past(signal_loss_flag))
		else $error("locked while signal lost");
	a_ref_tracks_loss: assert property (ref_clock_track == $past(signal_loss_flag))
		else $error("reference tracking not following loss");
	a_loss_after_quiet: assert property ($rose(signal_loss_flag) |-> quiet_r >= 10'd600)
		else $error("loss flagged too early");
	a_legacy_sdo_off: assert property (host_port_select_n [*8] |-> !host_dout_eq_enable_1_oe)
		else $error("shared pin driven in legacy mode");

	c_loss_clear: cover property ($fell(signal_loss_flag));
	c_loss_set: cover property ($rose(signal_loss_flag));
	c_locked: cover property ($rose(locked));
endmodule : sil_front_asserts

bind sil_front sil_front_asserts chk_u (.clk, .sys_rst, .host_port_select_n, .host_dout_eq_enable_1_oe, .input_select,
	.serial_video_input, .input_power_en, .trace_eq_setting, .serial_data_out, .data_mute, .signal_loss_flag,
	.locked, .ref_clock_track);

// file: tb/sil_video_src.sv
// Serial video source model: sliced activity of four inputs
`timescale 1ns/1ns
module sil_video_src #(
	parameter int HALF = 10
) (
	input  wire logic       clk,
	input  wire logic [3:0] run,
	output logic      [3:0] lanes
);
	logic [7:0] cnt_r = 8'h00;

	initial lanes = 4'h0;

	always @(negedge clk) begin
		cnt_r <= (cnt_r == 8'(HALF - 1)) ? 8'h00 : cnt_r + 8'h01;
		if (cnt_r == 8'(HALF - 1))
			lanes <= lanes ^ run;
	end
endmodule : sil_video_src

// file: tb/sil_front_bench.sv
// Testbench for the input select, signal-loss and lock block
`timescale 1ns/1ns
module sil_front_bench;
	logic clk, sys_rst, host_port_select_n, host_din_eq_enable_0, host_clock_eq_enable_2;
	logic host_select_eq_enable_3, pll_freq_ok, pll_phase_ok, pll_harmonic, eq1_drv;
	logic [1:0]  input_select;
	logic [3:0]  run;
	logic [15:0] r;
	int          n, checks, mismatches;
	wire         host_dout_eq_enable_1_o, host_dout_eq_enable_1_oe, host_dout_eq_enable_1_i;
	wire         serial_data_out, data_mute, signal_loss_flag, locked, ref_clock_track;
	wire [3:0]   serial_video_input, input_power_en;
	wire [7:0]   trace_eq_setting;
	wire [1:0]   reclock_rate;

	assign host_dout_eq_enable_1_i = host_dout_eq_enable_1_oe ? host_dout_eq_enable_1_o : eq1_drv;

	sil_front dut_u (.clk, .sys_rst, .host_port_select_n, .host_din_eq_enable_0, .host_dout_eq_enable_1_i,
		.host_dout_eq_enable_1_o, .host_dout_eq_enable_1_oe, .host_clock_eq_enable_2, .host_select_eq_enable_3,
		.input_select, .serial_video_input, .pll_freq_ok, .pll_phase_ok, .pll_harmonic, .input_power_en,
		.trace_eq_setting, .serial_data_out, .data_mute, .signal_loss_flag, .locked, .ref_clock_track, .reclock_rate);
	sil_video_src #(.HALF(10)) src_u (.clk, .run, .lanes(serial_video_input));

	always #4 clk = ~clk;

	task close_out;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wt(input int k);
		repeat (k) @(negedge clk);
	endtask : wt

	task pins(input logic [3:0] p);
		{host_select_eq_enable_3, host_clock_eq_enable_2, eq1_drv, host_din_eq_enable_0} = p;
	endtask : pins

	task wait_flag(input logic v, input int lim);
		n = 0;
		while (signal_loss_flag !== v && n < lim) begin
			wt(1);
			n++;
		end
	endtask : wait_flag

	// Mode 0 frame, each clock phase 56 ns to stay under 10 MHz
	task automatic spi(input logic [15:0] c, input logic [15:0] d, output logic [15:0] q);
		logic [31:0] f;
		f = {c, d};
		q = 16'h0000;
		host_select_eq_enable_3 = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			host_din_eq_enable_0 = f[i];
			wt(7);
			host_clock_eq_enable_2 = 1'b1;
			if (i < 16)
				q[i] = host_dout_eq_enable_1_i;
			wt(7);
			host_clock_eq_enable_2 = 1'b0;
		end
		wt(7);
		host_select_eq_enable_3 = 1'b1;
		wt(10);
	endtask : spi

	initial begin
		wt(30000);
		mismatches++;
		close_out;
	end

	initial begin
		clk = 1'b0; sys_rst = 1'b1; host_port_select_n = 1'b1; pins(4'h0); input_select = 2'h0; run = 4'h0;
		pll_freq_ok = 1'b1; pll_phase_ok = 1'b1; pll_harmonic = 1'b0; checks = 0; mismatches = 0;
		wt(16);
		sys_rst = 1'b0;
		wt(8);
		chk(16'(signal_loss_flag), 16'h0001);
		chk(16'(data_mute), 16'h0001);
		chk(16'(reclock_rate), 16'(sil_pkg::RATE_2970M));
		for (int s = 0; s < 4; s++) begin
			for (int v = 0; v < 2; v++) begin
				input_select = 2'(s);
				pins(v != 0 ? 4'h1 << s : ~(4'h1 << s));
				wt(8);
				chk(16'(input_power_en), 16'h0001 << s);
				chk(16'(trace_eq_setting), v != 0 ? 16'(sil_pkg::EQ_MED) << (2 * s) : 16'h0000);
			end
		end
		chk(16'(host_dout_eq_enable_1_oe), 16'h0000);
		input_select = 2'h0;
		pins(4'h0);
		wt(8);
		run = 4'h1;
		wait_flag(1'b0, 800);
		wt(3);
		chk(16'(n < 700), 16'h0001);
		chk(16'({data_mute, locked}), 16'h0001);
		chk(16'(ref_clock_track), 16'h0000);
		pll_harmonic = 1'b1;
		wt(8);
		chk(16'(locked), 16'h0000);
		pll_harmonic = 1'b0;
		run = 4'h0;
		wait_flag(1'b1, 1400);
		chk(16'(n >= 620 && n <= 1260), 16'h0001);
		wt(3);
		chk(16'({data_mute, serial_data_out}), 16'h0003);
		chk(16'(ref_clock_track), 16'h0001);
		host_port_select_n = 1'b0;
		pins(4'h8);
		input_select = 2'h2;
		wt(10);
		chk(16'(trace_eq_setting), 16'(sil_pkg::EQ_MED) << 4);
		spi(16'h8002, 16'h0000, r);
		chk(r, 16'(sil_pkg::LOSS_CTL_RST));
		spi(16'h0002, 16'h0013, r);
		spi(16'h8002, 16'h0000, r);
		chk(r, 16'h0013);
		chk(16'(host_dout_eq_enable_1_oe), 16'h0001);
		spi(16'h8007, 16'h0000, r);
		chk(r, 16'h0000);
		spi(16'h8004, 16'h0000, r);
		chk(r, 16'h000a);
		for (int g = 0; g < 3; g++) begin
			spi(16'h0003, 16'((g + 1) * 4 + (g == 2 ? 3 : g)), r);
			chk(16'(trace_eq_setting), 16'(g) << 4);
			chk(16'(reclock_rate), 16'(g + 1));
		end
		spi(16'h0002, 16'h0017, r);
		chk(16'(host_dout_eq_enable_1_oe), 16'h0000);
		run = 4'h4;
		wt(25);
		run = 4'h0;
		wait_flag(1'b0, 700);
		chk(16'(n < 640), 16'h0001);
		wt(8);
		chk(16'(serial_data_out), 16'(serial_video_input[2]));
		spi(16'h8004, 16'h0000, r);
		chk(r, 16'h0009);
		close_out;
	end
endmodule : sil_front_bench
